// ---- dv/dcrm_checker_sva.sv ----
// Port-level assertions for the clock and reset manager
`timescale 1ns/1ps
module dcrm_checker #(
  parameter LOCK_CYCLES = 40
) (
  input logic       aclk,
  input logic       aresetn,
  input logic       s_axi_awready,
  input logic       s_axi_bvalid,
  input logic       s_axi_bready,
  input logic       s_axi_arready,
  input logic       s_axi_rvalid,
  input logic       s_axi_rready,
  input logic       pll_lock_lost,
  input logic       pll_bypass,
  input logic [5:0] host_domain_clk_en,
  input logic       coproc_clock_run,
  input logic       coproc_core_rstn,
  input logic       coproc_periph_rstn,
  input logic       host_periph_rstn,
  input logic       host_core_rstn,
  input logic       ext_periph_rstn
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  // Saturating so a long bypass cannot wrap and fake a short one
  logic [15:0] byp_cnt_reg;
  logic        wr_done_reg;
  always_ff @(posedge aclk) begin
    if (!aresetn || !pll_bypass) byp_cnt_reg <= 16'h0000;
    else if (byp_cnt_reg != 16'hFFFF) byp_cnt_reg <= byp_cnt_reg + 16'h0001;
    wr_done_reg <= aresetn && s_axi_bvalid && s_axi_bready;
  end
  ////////////////////////////////////////////////////////////////
  sequence s_lock_loss;
    !pll_bypass && pll_lock_lost;
  endsequence
  sequence s_core_pulse;
    !host_core_rstn ##1 host_core_rstn;
  endsequence
  property p_bvalid_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
  property p_rvalid_hold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid; endproperty
  property p_aw_refused; s_axi_bvalid |-> !s_axi_awready; endproperty
  property p_ar_refused; s_axi_rvalid |-> !s_axi_arready; endproperty
  property p_bypass_on_loss; s_lock_loss |-> ##[1:2] pll_bypass; endproperty
  property p_lock_time; $fell(pll_bypass) |-> byp_cnt_reg >= LOCK_CYCLES - 1; endproperty
  property p_coproc_gated; host_domain_clk_en[4] |-> coproc_clock_run || $past(coproc_clock_run); endproperty
  property p_periph_by_write; $rose(host_periph_rstn) |-> wr_done_reg; endproperty
  property p_soft_pulse; $fell(host_core_rstn) |-> s_core_pulse; endproperty
  property p_soft_holds;
    $fell(host_core_rstn) |-> ##2 !coproc_core_rstn && !coproc_periph_rstn && !ext_periph_rstn;
  endproperty
  a_bvalid_hold: assert property (p_bvalid_hold) else $error("bvalid dropped early");
  a_rvalid_hold: assert property (p_rvalid_hold) else $error("rvalid dropped early");
  a_aw_refused: assert property (p_aw_refused) else $error("awready during bvalid");
  a_ar_refused: assert property (p_ar_refused) else $error("arready during rvalid");
  a_bypass_on_loss: assert property (p_bypass_on_loss) else $error("no bypass after lock loss");
  a_lock_time: assert property (p_lock_time) else $error("lock came too soon");
  a_coproc_gated: assert property (p_coproc_gated) else $error("coproc domain runs ungated");
  a_periph_by_write: assert property (p_periph_by_write) else $error("periph release without write");
  a_soft_pulse: assert property (p_soft_pulse) else $error("host core reset not one cycle");
  a_soft_holds: assert property (p_soft_holds) else $error("coproc released by soft reset");
endmodule

// ---- dv/tb.sv ----
// Self-checking testbench for the clock and reset manager
`timescale 1ns/1ps
`include "dcrm_map.vh"
module tb;
  // Short lock time keeps polling loops brief
  localparam LOCK = 12;
  logic        aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        pll_lock_lost, ok;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  rsp;
  wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, pll_bypass;
  wire  [1:0]  s_axi_bresp, s_axi_rresp, synth_div;
  wire  [31:0] s_axi_rdata;
  wire  [4:0]  synth_mult, coproc_gate_en;
  wire  [5:0]  host_domain_clk_en;
  wire  [2:0]  coproc_sio_clk_en;
  wire  [8:0]  host_gate_en;
  wire         host_timer_clk_en, coproc_clock_run, coproc_core_rstn, host_periph_rstn;
  wire         coproc_periph_rstn, host_core_rstn, ext_periph_rstn, sync_scalable_mode;
  integer      fails, checks, i, n, r;
  integer      cnt [0:9];
  logic [7:0]  r_addr [0:5] = '{8'h10, 8'h1C, 8'h04, 8'h14, 8'h20, 8'h30};
  logic [31:0] r_wd   [0:5] = '{32'h1FF, 32'h1F, 32'h1000, 32'h1, 32'h1, 32'h5};
  logic [31:0] r_rd   [0:5] = '{32'h1FF, 32'h1F, 32'h1000, 32'h1, 32'h1, 32'h0};
  logic [31:0] r_out  [0:5] = '{32'h1FF, 32'h1F, 32'h1, 32'h1, 32'h1, 32'h0};
  logic [1:0]  r_rsp  [0:5] = '{2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h2};

  dcrm_top #(.LOCK_CYCLES(LOCK)) i_dcrm_top (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .pll_lock_lost, .pll_bypass, .synth_mult, .synth_div, .host_domain_clk_en, .host_timer_clk_en,
    .coproc_sio_clk_en, .host_gate_en, .coproc_gate_en, .coproc_clock_run, .coproc_core_rstn,
    .host_periph_rstn, .coproc_periph_rstn, .host_core_rstn, .ext_periph_rstn, .sync_scalable_mode);

  always #25 aclk = ~aclk;
  ////////////////////////////////////////////////////////////////
  task summarize;
    if (fails == 0 && checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    checks = checks + 1;
    if (got !== exp) begin
      fails = fails + 1;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    fails = fails + 1;
    $display("MISMATCH %0t wait timed out", $time);
    summarize;
  endtask
  task settle;
    @(posedge aclk);
    #1;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ok = 0;
    for (n = 0; n < 40 && !ok; n = n + 1) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) begin
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
        ok = 1;
      end
    end
    if (!ok) tmo;
  endtask
  task rdw(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    ok = 0;
    for (n = 0; n < 40 && !ok; n = n + 1) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) begin
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
        ok = 1;
      end
    end
    if (!ok) tmo;
  endtask
  // First read must still see the lock bit clear, then wait for lock
  task poll;
    rdw(`DCRM_OFF_DPLL_CTRL);
    chk(rd[0], 1'b0);
    for (i = 0; i < 40 && rd[0] !== 1'b1; i = i + 1) rdw(`DCRM_OFF_DPLL_CTRL);
    if (rd[0] !== 1'b1) tmo;
  endtask
  task count(input integer cyc);
    for (i = 0; i < 10; i = i + 1) cnt[i] = 0;
    repeat (cyc) begin
      settle;
      for (i = 0; i < 6; i = i + 1) cnt[i] = cnt[i] + host_domain_clk_en[i];
      cnt[6] = cnt[6] + host_timer_clk_en;
      for (i = 0; i < 3; i = i + 1) cnt[7+i] = cnt[7+i] + coproc_sio_clk_en[i];
    end
  endtask
  // Fractional tick phase makes counts differ by up to one pulse per divide step
  function logic near(input integer a, input integer b, input integer tol);
    near = (a - b <= tol) && (b - a <= tol);
  endfunction
  function logic [31:0] view(input logic [7:0] a);
    case (a)
      8'h10: view = {23'h0, host_gate_en};
      8'h1C: view = {27'h0, coproc_gate_en};
      8'h04: view = {31'h0, sync_scalable_mode};
      8'h14: view = {31'h0, host_periph_rstn};
      8'h20: view = {31'h0, coproc_periph_rstn};
      default: view = 32'h0;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    aresetn = 1'b0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, pll_lock_lost} = 6'h0;
    s_axi_awaddr = 8'h0;
    s_axi_araddr = 8'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    fails = 0;
    checks = 0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    chk(pll_bypass, 1'b1);
    rdw(`DCRM_OFF_DPLL_CTRL);
    chk(rd, `DCRM_PLL_CTRL_RST);
    rdw(`DCRM_OFF_HOST_CKDIV);
    chk(rd, `DCRM_HDIV_RST);
    rdw(`DCRM_OFF_CLK_STATUS);
    chk(rd, 32'h1);
    for (r = 0; r < 6; r = r + 1) begin
      wr(r_addr[r], r_wd[r]);
      chk(rsp, r_rsp[r]);
      settle;
      chk(view(r_addr[r]), r_out[r]);
      rdw(r_addr[r]);
      chk(rd, r_rd[r]);
      chk(rsp, r_rsp[r]);
    end
    wr(`DCRM_OFF_CLK_STATUS, 32'h0);
    chk(rsp, 2'h2);
    // Fields first, request in a second write
    wr(`DCRM_OFF_DPLL_CTRL, 32'h1CA0);
    wr(`DCRM_OFF_DPLL_CTRL, 32'h1CB0);
    poll;
    chk(synth_mult, 5'h19);
    chk(synth_div, 2'h1);
    chk(pll_bypass, 1'b0);
    rdw(`DCRM_OFF_CLK_STATUS);
    chk(rd, 32'h4);
    wr(`DCRM_OFF_COP_CKDIV, 32'h3448);
    wr(`DCRM_OFF_HOST_CKDIV, 32'h04E4);
    count(640);
    chk(near(cnt[0], 250, 3), 1'b1);
    chk(near(cnt[0], 2 * cnt[1], 2), 1'b1);
    chk(near(cnt[0], 4 * cnt[2], 4), 1'b1);
    chk(near(cnt[0], 4 * cnt[3], 4), 1'b1);
    chk(cnt[4], 0);
    chk(near(cnt[0], 2 * cnt[5], 2), 1'b1);
    chk(cnt[6], 640);
    chk(near(cnt[0], 8 * cnt[7], 8), 1'b1);
    chk(cnt[8], 640);
    chk(near(cnt[0], 4 * cnt[9], 4), 1'b1);
    wr(`DCRM_OFF_HOST_CKDIV, 32'h24E4);
    settle;
    chk(coproc_clock_run, 1'b1);
    chk(coproc_core_rstn, 1'b0);
    count(64);
    chk(cnt[4] > 0, 1'b1);
    for (r = 1; r < 4; r = r + 1) begin
      wr(`DCRM_OFF_HOST_RST1, r * 2);
      settle;
      chk(coproc_core_rstn, r == 3);
    end
    @(posedge aclk);
    pll_lock_lost <= 1'b1;
    @(posedge aclk);
    pll_lock_lost <= 1'b0;
    repeat (2) settle;
    chk(pll_bypass, 1'b1);
    poll;
    chk(pll_bypass, 1'b0);
    wr(`DCRM_OFF_SW_RESET, 32'h1);
    repeat (3) settle;
    chk(host_core_rstn, 1'b1);
    chk(coproc_core_rstn, 1'b0);
    chk(coproc_periph_rstn, 1'b0);
    chk(ext_periph_rstn, 1'b0);
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    settle;
    chk(pll_bypass, 1'b1);
    chk(host_gate_en, 9'h0);
    rdw(`DCRM_OFF_DPLL_CTRL);
    chk(rd, `DCRM_PLL_CTRL_RST);
    summarize;
  end
endmodule

bind dcrm_top dcrm_checker #(.LOCK_CYCLES(LOCK_CYCLES)) i_dcrm_checker (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awready(s_axi_awready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready), .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .pll_lock_lost(pll_lock_lost), .pll_bypass(pll_bypass),
  .host_domain_clk_en(host_domain_clk_en), .coproc_clock_run(coproc_clock_run),
  .coproc_core_rstn(coproc_core_rstn), .coproc_periph_rstn(coproc_periph_rstn),
  .host_periph_rstn(host_periph_rstn), .host_core_rstn(host_core_rstn), .ext_periph_rstn(ext_periph_rstn));

// ---- verilog/dcrm_clk_div.v ----
// Glitch-free divided clock-enable generator for one clock domain
`timescale 1ns/1ps
module dcrm_clk_div #(
  parameter W = 4
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [W-1:0] ratio,
  input  wire         gate,
  input  wire         src_ref,
  input  wire         pll_tick,
  output reg          clk_en
);
  reg [W-1:0] cnt_reg;
  reg [W-1:0] ratio_reg;
  wire        tick;

  assign tick = src_ref ? 1'b1 : pll_tick;

  // New ratio only loaded at a period boundary so no runt period appears
  always @(posedge aclk) begin
    if (!aresetn) begin
      cnt_reg   <= {W{1'b0}};
      ratio_reg <= {W{1'b0}};
      clk_en    <= 1'b0;
    end else begin
      clk_en <= 1'b0;
      if (tick) begin
        if (cnt_reg >= ratio_reg) begin
          cnt_reg   <= {W{1'b0}};
          ratio_reg <= src_ref ? {W{1'b0}} : ratio;
          clk_en    <= gate;
        end else begin
          cnt_reg <= cnt_reg + {{(W-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule

// ---- verilog/dcrm_map.vh ----
// Register offsets, field positions, reset values and timing counts of the clock and reset manager
`ifndef DCRM_MAP_VH
`define DCRM_MAP_VH
`define DCRM_OFF_DPLL_CTRL    8'h00
`define DCRM_OFF_SYS_STATUS   8'h04
`define DCRM_OFF_HOST_CKDIV   8'h08
`define DCRM_OFF_HOST_RST1    8'h0C
`define DCRM_OFF_HOST_IDLE2   8'h10
`define DCRM_OFF_HOST_RST2    8'h14
`define DCRM_OFF_COP_CKDIV    8'h18
`define DCRM_OFF_COP_IDLE2    8'h1C
`define DCRM_OFF_COP_RST2     8'h20
`define DCRM_OFF_SW_RESET     8'h24
`define DCRM_OFF_CLK_STATUS   8'h28
// Synthesizer control fields
`define DCRM_DPLL_MULTIPLIER_LSB     7
`define DCRM_DPLL_MULTIPLIER_W       5
`define DCRM_PLL_DIV_LSB      5
`define DCRM_PLL_DIV_W        2
`define DCRM_PLL_LOCKREQ_BIT  4
`define DCRM_PLL_REINIT_BIT   12
`define DCRM_PLL_LOCK_BIT     0
`define DCRM_PLL_CTRL_RST     32'h0000_2000
// System status: clocking scheme select
`define DCRM_SCHEME_LSB       11
`define DCRM_SCHEME_W         3
`define DCRM_SCHEME_SCALABLE  3'h2
// Host divide control
`define DCRM_HDIV_PER_LSB     0
`define DCRM_HDIV_MMU_LSB     2
`define DCRM_HDIV_LCD_LSB     4
`define DCRM_HDIV_CORE_LSB    6
`define DCRM_HDIV_COP_LSB     8
`define DCRM_HDIV_TC_LSB      10
`define DCRM_HDIV_TIMSRC_BIT  12
`define DCRM_HDIV_COPGATE_BIT 13
`define DCRM_HDIV_RST         32'h0000_1000
// Host reset control one
`define DCRM_HRST1_COPEN_BIT  1
`define DCRM_HRST1_COPRST_BIT 2
// Coprocessor divide control
`define DCRM_CDIV_PER_LSB     0
`define DCRM_CDIV_PER_W       4
`define DCRM_CDIV_UART_LSB    4
`define DCRM_CDIV_GPIO_LSB    8
`define DCRM_CDIV_SIO_W       3
`define DCRM_CDIV_GPIOSRC_BIT 12
`define DCRM_CDIV_TIMSRC_BIT  13
`define DCRM_CDIV_UARTSRC_BIT 14
`define DCRM_CDIV_RST         32'h0000_0000
// Host idle gates: 9 bits, coprocessor idle gates: 5 bits
`define DCRM_HIDLE_W          9
`define DCRM_CIDLE_W          5
// Lock settling time in ns at the 50 ns reference period
`define DCRM_LOCK_TIME_NS     2000
`define DCRM_CLK_PERIOD_NS    50
`endif

// ---- verilog/dcrm_top.v ----
// Clock and reset manager: synthesizer control, domain dividers, gates and reset releases
// Overview of operation
// [RL1] Output is reference times multiplier over divider+1
// [RL2] Lock loss with reinit set re-locks via bypass
// [RL3] Writing lock request starts locking sequence
// [RL4] Lock status bit set when frequency reached
// [RL5] Software programs fields before requesting lock
// [RL6] Scheme 010b selects synchronous scalable mode
// [RL7] Separate divide fields for six host domains
// [RL8] Divide codes 0,1,2 give 1,2,4
// [RL9] Timer source zero uses input reference
// [RL10] Coprocessor clock gate runs clock, core held
// [RL11] Core released only with both bits set
// [RL12] Software enables clock before core release
// [RL13] Host idle register gates nine clocks
// [RL14] Peripheral release bit frees host peripherals
// [RL15] Coprocessor divides make peripheral, pio, serial clocks
// [RL16] Source select zero means reference, one PLL
// [RL17] Coprocessor idle register gates five clocks
// [RL18] Peripheral release bit frees coprocessor peripherals
// [RL19] Software reset frees host, holds coprocessor, externals
// [RL20] Divide, source and gate changes glitch free
// [RL21] Bypass or unlocked: reference output, lock zero
`timescale 1ns/1ps
`include "dcrm_map.vh"
module dcrm_top #(
  parameter LOCK_CYCLES = (`DCRM_LOCK_TIME_NS + `DCRM_CLK_PERIOD_NS - 1) / `DCRM_CLK_PERIOD_NS
) (
  input  wire        aclk,
  input  wire        aresetn,
  input  wire [7:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [7:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  input  wire        pll_lock_lost,
  output reg         pll_bypass,
  output reg  [4:0]  synth_mult,
  output reg  [1:0]  synth_div,
  output wire [5:0]  host_domain_clk_en,
  output wire        host_timer_clk_en,
  output wire [2:0]  coproc_sio_clk_en,
  output reg  [8:0]  host_gate_en,
  output reg  [4:0]  coproc_gate_en,
  output reg         coproc_clock_run,
  output reg         coproc_core_rstn,
  output reg         host_periph_rstn,
  output reg         coproc_periph_rstn,
  output reg         host_core_rstn,
  output reg         ext_periph_rstn,
  output reg         sync_scalable_mode
);
  localparam ST_BYPASS = 3'b001;
  localparam ST_LOCKING = 3'b010;
  localparam ST_LOCKED = 3'b100;

  // 2-bit code to divide ratio minus one: 0->0, 1->1, 2->3
  function [3:0] dcrm_ratio;
    input [1:0] code;
    begin
      case (code)
        2'h0: dcrm_ratio = 4'h0;
        2'h1: dcrm_ratio = 4'h1;
        2'h2: dcrm_ratio = 4'h3;
        default: dcrm_ratio = 4'h3;
      endcase
    end
  endfunction

  function [31:0] dcrm_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0]  be;
    integer i;
    begin
      dcrm_merge = old;
      for (i = 0; i < 4; i = i + 1) begin
        if (be[i]) begin
          dcrm_merge[i*8 +: 8] = wd[i*8 +: 8];
        end
      end
    end
  endfunction

  reg [31:0] pll_ctrl_reg;
  reg [31:0] sys_status_reg;
  reg [31:0] host_ckdiv_reg;
  reg [31:0] host_rst1_reg;
  reg [31:0] host_idle_reg;
  reg [31:0] host_rst2_reg;
  reg [31:0] cop_ckdiv_reg;
  reg [31:0] cop_idle_reg;
  reg [31:0] cop_rst2_reg;
  reg [2:0]  pll_state_reg;
  reg [15:0] lock_cnt_reg;
  reg [7:0]  pll_phase_reg;
  reg [7:0]  aw_addr_reg;
  reg        aw_full_reg;
  reg [31:0] w_data_reg;
  reg [3:0]  w_strb_reg;
  reg        w_full_reg;
  reg        soft_rst_reg;
  wire       do_write;
  wire       pll_locked;
  wire       pll_tick;
  wire [7:0] phase_sum;
  wire [7:0] pll_wrap;

  assign s_axi_awready = !aw_full_reg && !s_axi_bvalid;
  assign s_axi_wready  = !w_full_reg && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = aw_full_reg && w_full_reg && !s_axi_bvalid;
  assign pll_locked    = (pll_state_reg == ST_LOCKED);

  ////////////////////////////////////////////////////////////////////////////
  // Synthesized rate as a fractional tick: phase += mult, wrap at 32*(div+1)
  // [RL1] rate scaling model
  assign phase_sum = pll_phase_reg + {3'b000, synth_mult};
  // Widened by one bit first so divider code 3 cannot wrap to zero
  assign pll_wrap  = {({1'b0, synth_div} + 3'h1), 5'h00};
  // [RL21] bypass follows reference
  assign pll_tick = pll_locked ? (phase_sum >= pll_wrap) : 1'b1;

  always @(posedge aclk) begin
    if (!aresetn) begin
      pll_phase_reg <= 8'h00;
    end else if (!pll_locked) begin
      pll_phase_reg <= 8'h00;
    end else if (pll_tick) begin
      pll_phase_reg <= phase_sum - pll_wrap;
    end else begin
      pll_phase_reg <= phase_sum;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Lock state machine
  always @(posedge aclk) begin
    if (!aresetn) begin
      pll_state_reg <= ST_BYPASS;
      lock_cnt_reg  <= 16'h0000;
      pll_bypass    <= 1'b1;
      synth_mult    <= 5'h00;
      synth_div     <= 2'h0;
    end else begin
      case (pll_state_reg)
        ST_BYPASS: begin
          pll_bypass <= 1'b1;
          // [RL3] lock request starts
          if (do_write && aw_addr_reg == `DCRM_OFF_DPLL_CTRL &&
              w_strb_reg[0] && w_data_reg[`DCRM_PLL_LOCKREQ_BIT]) begin
            pll_state_reg <= ST_LOCKING;
            lock_cnt_reg  <= 16'h0000;
            synth_mult    <= pll_ctrl_reg[`DCRM_DPLL_MULTIPLIER_LSB +: `DCRM_DPLL_MULTIPLIER_W];
            synth_div     <= pll_ctrl_reg[`DCRM_PLL_DIV_LSB +: `DCRM_PLL_DIV_W];
          end
        end
        ST_LOCKING: begin
          pll_bypass <= 1'b1;
          // [RL4] lock after settle
          if (lock_cnt_reg >= LOCK_CYCLES[15:0] - 16'h0001) begin
            pll_state_reg <= ST_LOCKED;
            pll_bypass    <= 1'b0;
          end else begin
            lock_cnt_reg <= lock_cnt_reg + 16'h0001;
          end
        end
        ST_LOCKED: begin
          if (pll_lock_lost) begin
            pll_bypass   <= 1'b1;
            lock_cnt_reg <= 16'h0000;
            // [RL2] reinit on loss
            pll_state_reg <= pll_ctrl_reg[`DCRM_PLL_REINIT_BIT] ? ST_LOCKING : ST_BYPASS;
          end
        end
        default: begin
          pll_state_reg <= ST_BYPASS;
          pll_bypass    <= 1'b1;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write path
  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_reg    <= 1'b0;
      w_full_reg     <= 1'b0;
      aw_addr_reg    <= 8'h00;
      w_data_reg     <= 32'h0000_0000;
      w_strb_reg     <= 4'h0;
      s_axi_bvalid   <= 1'b0;
      s_axi_bresp    <= 2'b00;
      soft_rst_reg   <= 1'b0;
      pll_ctrl_reg   <= `DCRM_PLL_CTRL_RST;
      sys_status_reg <= 32'h0000_0000;
      host_ckdiv_reg <= `DCRM_HDIV_RST;
      host_rst1_reg  <= 32'h0000_0000;
      host_idle_reg  <= 32'h0000_0000;
      host_rst2_reg  <= 32'h0000_0000;
      cop_ckdiv_reg  <= `DCRM_CDIV_RST;
      cop_idle_reg   <= 32'h0000_0000;
      cop_rst2_reg   <= 32'h0000_0000;
    end else begin
      soft_rst_reg <= 1'b0;
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr_reg <= s_axi_awaddr;
        aw_full_reg <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
        w_full_reg <= 1'b1;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
      if (do_write) begin
        aw_full_reg  <= 1'b0;
        w_full_reg   <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= 2'b00;
        case (aw_addr_reg)
          `DCRM_OFF_DPLL_CTRL:  pll_ctrl_reg   <= dcrm_merge(pll_ctrl_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_SYS_STATUS: sys_status_reg <= dcrm_merge(sys_status_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_HOST_CKDIV: host_ckdiv_reg <= dcrm_merge(host_ckdiv_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_HOST_RST1:  host_rst1_reg  <= dcrm_merge(host_rst1_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_HOST_IDLE2: host_idle_reg  <= dcrm_merge(host_idle_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_HOST_RST2:  host_rst2_reg  <= dcrm_merge(host_rst2_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_COP_CKDIV:  cop_ckdiv_reg  <= dcrm_merge(cop_ckdiv_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_COP_IDLE2:  cop_idle_reg   <= dcrm_merge(cop_idle_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_COP_RST2:   cop_rst2_reg   <= dcrm_merge(cop_rst2_reg, w_data_reg, w_strb_reg);
          `DCRM_OFF_SW_RESET:   soft_rst_reg   <= w_strb_reg[0] & w_data_reg[0];
          `DCRM_OFF_CLK_STATUS: s_axi_bresp    <= 2'b10;
          default:              s_axi_bresp    <= 2'b10;
        endcase
        // Lock request is self-clearing; it never stores
        if (aw_addr_reg == `DCRM_OFF_DPLL_CTRL) begin
          pll_ctrl_reg[`DCRM_PLL_LOCKREQ_BIT] <= 1'b0;
          pll_ctrl_reg[`DCRM_PLL_LOCK_BIT]    <= 1'b0;
        end
      end
      // [RL19] software reset state
      if (soft_rst_reg) begin
        host_rst1_reg <= 32'h0000_0000;
        host_rst2_reg <= 32'h0000_0000;
        cop_rst2_reg  <= 32'h0000_0000;
        host_ckdiv_reg[`DCRM_HDIV_COPGATE_BIT] <= 1'b0;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read path
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'b00;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= 2'b00;
      case (s_axi_araddr)
        // [RL4] lock status read
        `DCRM_OFF_DPLL_CTRL:  s_axi_rdata <= {pll_ctrl_reg[31:1], pll_locked};
        `DCRM_OFF_SYS_STATUS: s_axi_rdata <= sys_status_reg;
        `DCRM_OFF_HOST_CKDIV: s_axi_rdata <= host_ckdiv_reg;
        `DCRM_OFF_HOST_RST1:  s_axi_rdata <= host_rst1_reg;
        `DCRM_OFF_HOST_IDLE2: s_axi_rdata <= host_idle_reg;
        `DCRM_OFF_HOST_RST2:  s_axi_rdata <= host_rst2_reg;
        `DCRM_OFF_COP_CKDIV:  s_axi_rdata <= cop_ckdiv_reg;
        `DCRM_OFF_COP_IDLE2:  s_axi_rdata <= cop_idle_reg;
        `DCRM_OFF_COP_RST2:   s_axi_rdata <= cop_rst2_reg;
        `DCRM_OFF_SW_RESET:   s_axi_rdata <= 32'h0000_0000;
        `DCRM_OFF_CLK_STATUS: s_axi_rdata <= {29'h0000_0000, pll_state_reg};
        default: begin
          s_axi_rdata <= 32'h0000_0000;
          s_axi_rresp <= 2'b10;
        end
      endcase
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Gates, resets and mode outputs, all registered
  always @(posedge aclk) begin
    if (!aresetn) begin
      host_gate_en       <= 9'h000;
      coproc_gate_en     <= 5'h00;
      coproc_clock_run   <= 1'b0;
      coproc_core_rstn   <= 1'b0;
      host_periph_rstn   <= 1'b0;
      coproc_periph_rstn <= 1'b0;
      host_core_rstn     <= 1'b0;
      ext_periph_rstn    <= 1'b0;
      sync_scalable_mode <= 1'b0;
    end else begin
      // [RL19] host core freed, externals held
      host_core_rstn  <= !soft_rst_reg;
      ext_periph_rstn <= host_rst2_reg[0] && cop_rst2_reg[0];
      // [RL6] scalable mode decode
      sync_scalable_mode <= sys_status_reg[`DCRM_SCHEME_LSB +: `DCRM_SCHEME_W] == `DCRM_SCHEME_SCALABLE;
      // [RL13] host idle gates
      host_gate_en <= host_idle_reg[`DCRM_HIDLE_W-1:0];
      // [RL17] coprocessor idle gates
      coproc_gate_en <= cop_idle_reg[`DCRM_CIDLE_W-1:0];
      // [RL10] clock runs, core held
      coproc_clock_run <= host_ckdiv_reg[`DCRM_HDIV_COPGATE_BIT];
      // [RL11] both bits release core
      coproc_core_rstn <= host_rst1_reg[`DCRM_HRST1_COPRST_BIT] && host_rst1_reg[`DCRM_HRST1_COPEN_BIT];
      // [RL14] host peripheral release
      host_periph_rstn <= host_rst2_reg[0];
      // [RL18] coprocessor peripheral release
      coproc_periph_rstn <= cop_rst2_reg[0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Domain dividers: per, mmu, lcd, core, coproc, tc
  // [RL7] six host domain dividers
  // [RL8] divide code decode
  // [RL20] glitch free dividers
  genvar g;
  generate
    for (g = 0; g < 6; g = g + 1) begin : g_host
      dcrm_clk_div #(.W(4)) u_div (
        .aclk     (aclk),
        .aresetn  (aresetn),
        .ratio    (dcrm_ratio(host_ckdiv_reg[2*g +: 2])),
        .gate     (g == 4 ? coproc_clock_run : 1'b1),
        .src_ref  (1'b0),
        .pll_tick (pll_tick),
        .clk_en   (host_domain_clk_en[g])
      );
    end
  endgenerate

  // [RL9] timer from reference
  dcrm_clk_div #(.W(4)) u_host_tim (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ratio    (4'h0),
    .gate     (1'b1),
    .src_ref  (!host_ckdiv_reg[`DCRM_HDIV_TIMSRC_BIT]),
    .pll_tick (pll_tick),
    .clk_en   (host_timer_clk_en)
  );

  // [RL15] coprocessor side dividers
  // [RL16] source select reference
  dcrm_clk_div #(.W(4)) u_cop_per (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ratio    (cop_ckdiv_reg[`DCRM_CDIV_PER_LSB +: `DCRM_CDIV_PER_W] - 4'h1),
    .gate     (coproc_gate_en[0]),
    .src_ref  (!cop_ckdiv_reg[`DCRM_CDIV_TIMSRC_BIT]),
    .pll_tick (pll_tick),
    .clk_en   (coproc_sio_clk_en[0])
  );
  dcrm_clk_div #(.W(4)) u_cop_uart (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ratio    ({1'b0, cop_ckdiv_reg[`DCRM_CDIV_UART_LSB +: `DCRM_CDIV_SIO_W]} - 4'h1),
    .gate     (1'b1),
    .src_ref  (!cop_ckdiv_reg[`DCRM_CDIV_UARTSRC_BIT]),
    .pll_tick (pll_tick),
    .clk_en   (coproc_sio_clk_en[1])
  );
  dcrm_clk_div #(.W(4)) u_cop_gpio (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .ratio    ({1'b0, cop_ckdiv_reg[`DCRM_CDIV_GPIO_LSB +: `DCRM_CDIV_SIO_W]} - 4'h1),
    .gate     (coproc_gate_en[4]),
    .src_ref  (!cop_ckdiv_reg[`DCRM_CDIV_GPIOSRC_BIT]),
    .pll_tick (pll_tick),
    .clk_en   (coproc_sio_clk_en[2])
  );
endmodule
